// [dv/arb_model.sv]
// bus arbiter model: grants a held request and paces transfer completions
`timescale 1ns/1ps

module arb_model #(
  parameter int SLOW = 0
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // request side and test control
  input  wire logic bus_request_out,
  input  wire logic stall,
  // grant and completions
  output logic      bus_granted,
  output logic      dma_xfer_done
);
  logic tick_r;

  // grant only a held request, complete one transfer per cycle or every other
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_granted   <= 1'b0;
      dma_xfer_done <= 1'b0;
      tick_r        <= 1'b0;
    end else begin
      tick_r        <= ~tick_r;
      bus_granted   <= bus_request_out & ~stall;
      dma_xfer_done <= bus_granted & bus_request_out & ((SLOW == 0) | tick_r);
    end
  end
endmodule : arb_model

// [dv/tb_top.sv]
// testbench: register fields, data path shaping and bus request thresholds
`timescale 1ns/1ps

module tb_top;
  logic clock = 0, resetn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, rxg = 0, txg = 0;
  logic rm = 0, stall = 1, gnt, done, req, hi_en, auto_st, lpbk;
  logic [4:0]  addr = 0, fill = 0;
  logic [7:0]  wd = 0, rdata, v = 8'h4A;
  logic [15:0] din = 0, ain = 0, rsa = 0, ad_o, lo_o, hi_o;
  logic [3:0]  blen;
  dcfg_pkg::data_config_s cfg;
  int error_cnt = 0, checked = 0, th, n, cnt;

  dma_data_config dut (.clock(clock), .resetn(resetn), .clk_en(clk_en), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .fifo_fill_bytes(fill), .receiving(rxg), .transmitting(txg), .bus_granted(gnt),
    .dma_xfer_done(done), .remove_pkt_cmd(rm), .dma_word_in(din), .dma_addr_in(ain),
    .remote_start_addr(rsa), .bus_request_out(req), .dma_ad_out(ad_o),
    .dma_addr_lo_out(lo_o), .dma_addr_hi_out(hi_o), .dma_addr_hi_en(hi_en),
    .burst_len(blen), .remote_auto_start(auto_st), .loopback_mode(lpbk), .cfg_out(cfg));
  arb_model #(.SLOW(1)) arb (.clock(clock), .resetn(resetn), .bus_request_out(req),
    .stall(stall), .bus_granted(gnt), .dma_xfer_done(done));

  // free running clock
  always #10 clock = ~clock;

  // pseudo random sequence
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  // receive threshold in bytes for a code, the same for either transfer width
  function automatic int rx_bytes(input logic [1:0] c, input logic w);
    int t[4] = '{2, 4, 8, 12};
    return t[c];
  endfunction : rx_bytes

  // one compare, reported at once
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle register write
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1; addr <= a; wd <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // wait cycles, then settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  // report counts and verdict
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // watchdog
  initial begin
    #400000;
    error_cnt++;
    results();
  end

  initial begin
    rsa <= 16'hA5C3;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    cyc(2);
    chk(cfg, 17'h00018);
    chk({hi_en, hi_o}, {1'b1, 16'hA5C3});
    chk(lpbk, 0);
    // random configurations with data path and remove-packet checks
    repeat (40) begin
      v = lfsr(v);
      wr(dcfg_pkg::DATA_CONFIG_IDX, v);
      wr(5'h0D, ~v); // unmapped address leaves the register alone
      chk(cfg, {v[0], v[1], v[2], v[3], v[4], v[6:5]});
      chk(lpbk, !v[3]);
      chk(blen, v[0] ? rx_bytes(v[6:5], 1) / 2 : rx_bytes(v[6:5], 0));
      @(posedge clock);
      reg_rd <= 1'b1; addr <= dcfg_pkg::DATA_CONFIG_IDX;
      din <= {lfsr(v), v}; ain <= {v, lfsr(v)}; rsa <= {~v, v};
      rm <= !v[1];
      @(posedge clock);
      reg_rd <= 1'b0; rm <= 1'b0;
      #1;
      chk(rdata, 0);
      chk(auto_st, v[4] & !v[1]);
      chk(ad_o, (v[0] & v[1]) ? {v, lfsr(v)} : {lfsr(v), v});
      chk(lo_o, {v, lfsr(v) & {7'h7F, ~v[0]}});
      chk({hi_en, hi_o}, v[2] ? {1'b1, ~v, v} : 17'h0);
    end
    // a low enable ignores a write
    clk_en <= 1'b0;
    wr(dcfg_pkg::DATA_CONFIG_IDX, 8'h55);
    chk(cfg, {v[0], v[1], v[2], v[3], v[4], v[6:5]});
    clk_en <= 1'b1;
    // bus request thresholds and burst lengths for every code in both widths
    for (int k = 0; k < 8; k++) begin
      wr(dcfg_pkg::DATA_CONFIG_IDX, 8'h0C | {1'b0, k[1:0], 5'h00} | {7'h00, k[2]});
      th = rx_bytes(k[1:0], k[2]);
      rxg <= 1; fill <= 5'(th - 1);
      cyc(3);
      chk(req, 0);
      fill <= 5'(th);
      cyc(3);
      chk(req, 1);
      rxg <= 0; txg <= 1; fill <= 5'(14 - th);
      cyc(3);
      chk(req, 0);
      fill <= 5'(13 - th);
      cyc(3);
      chk(req, 1);
      stall <= 1'b0;
      n = 0;
      cnt = 0;
      while (req === 1'b1 && n < 60) begin
        if (done === 1'b1) cnt++;
        cyc(1);
        n++;
      end
      stall <= 1'b1; txg <= 0; fill <= 0;
      chk(req, 0);
      chk(cnt, k[2] ? th / 2 : th);
      cyc(2);
    end
    results();
  end
endmodule : tb_top

// [include/dcfg_pkg.sv]
// package: register map, field layout and fifo threshold tables for the data configuration block
package dcfg_pkg;

  // register index and address width of the host port
  localparam logic [4:0] DATA_CONFIG_IDX  = 5'h0E;
  localparam int         ADDR_W           = 5;

  // field positions inside data_config_reg
  localparam int WORD_SEL_BIT    = 0;
  localparam int LANE_ORDER_BIT  = 1;
  localparam int LONG_ADDR_BIT   = 2;
  localparam int LOOP_GATE_BIT   = 3;
  localparam int AUTO_REMOTE_BIT = 4;
  localparam int THR_LO          = 5;
  localparam int THR_HI          = 6;

  // reset value: long address set, loopback gate at normal, rest clear
  localparam logic [6:0] DATA_CONFIG_RST = 7'h0C;

  // transmit threshold base in bytes
  localparam logic [4:0] TX_BASE_BYTES = 5'h0D;

  // decoded configuration carried to the dma logic
  typedef struct packed {
    logic       word_transfer_sel;
    logic       byte_lane_order;
    logic       long_address_sel;
    logic       loopback_gate;
    logic       auto_remote;
    logic [1:0] fifo_threshold;
  } data_config_s;

  // receive threshold in fifo bytes per code
  function automatic logic [4:0] rx_thresh_bytes(input logic [1:0] code);
    logic [4:0] r;
    r = 5'h02;
    case (code)
      2'h0: r = 5'h02;
      2'h1: r = 5'h04;
      2'h2: r = 5'h08;
      default: r = 5'h0C;
    endcase
    return r;
  endfunction : rx_thresh_bytes

endpackage : dcfg_pkg

// [src/dma_data_config.sv]
// module: data configuration register with bus request and dma data path shaping
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

// Notes on behaviour
// (R1) word field selects byte or word transfers
// (R2) word mode: 32k words, A0 held low
// (R3) byte order swaps the two lanes
// (R4) byte order ignored in byte mode
// (R5) long address: single 32-bit versus dual 16-bit
// (R6) long address drives remote start as A16-A31
// (R7) long address set at power up
// (R8) gate low enters loopback, host programs transmit
// (R9) auto remote lets remove-packet run remote dma
// (R10) host avoids auto remote with swapped lanes
// (R11) two-bit code maps fifo threshold
// (R12) receive: request bus at fill threshold
// (R13) transmit threshold is 13 minus receive
// (R14) burst length follows the threshold
// (R15) host writes this before remote byte counts
// (R16) bit 7 ignored, register not readable
module dma_data_config #(
  parameter int ADDR_W = dcfg_pkg::ADDR_W
) (
  // clock, reset, enable
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  // host register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // fifo state from the fifo logic, bus grant and transfer done from the arbiter
  input  wire logic [4:0]        fifo_fill_bytes,
  input  wire logic              receiving,
  input  wire logic              transmitting,
  input  wire logic              bus_granted,
  input  wire logic              dma_xfer_done,
  // remove-packet command
  input  wire logic              remove_pkt_cmd,
  // dma data and address in
  input  wire logic [15:0]       dma_word_in,
  input  wire logic [15:0]       dma_addr_in,
  input  wire logic [15:0]       remote_start_addr,
  // outputs toward the system bus
  output logic                   bus_request_out,
  output logic      [15:0]       dma_ad_out,
  output logic      [15:0]       dma_addr_lo_out,
  output logic      [15:0]       dma_addr_hi_out,
  output logic                   dma_addr_hi_en,
  output logic      [3:0]        burst_len,
  output logic                   remote_auto_start,
  output logic                   loopback_mode,
  output dcfg_pkg::data_config_s cfg_out
);

  // elaboration check: the index must fit the address port
  if (ADDR_W < 4) begin : g_addr_chk
    $error("address too narrow for register index");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register

  logic [6:0] data_config_reg_r;
  dcfg_pkg::data_config_s cfg;

  // write only, bit 7 dropped, resets with long address set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      data_config_reg_r <= dcfg_pkg::DATA_CONFIG_RST; // see (R7)
    end else if (clk_en && reg_wr && reg_addr == ADDR_W'(dcfg_pkg::DATA_CONFIG_IDX)) begin
      data_config_reg_r <= reg_wdata[6:0]; // see (R16)
    end
  end

  // no readable register: reads return zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00; // see (R16)
    end
  end

  // field decode
  always_comb begin
    cfg.word_transfer_sel = data_config_reg_r[dcfg_pkg::WORD_SEL_BIT];
    cfg.byte_lane_order   = data_config_reg_r[dcfg_pkg::LANE_ORDER_BIT];
    cfg.long_address_sel  = data_config_reg_r[dcfg_pkg::LONG_ADDR_BIT];
    cfg.loopback_gate     = data_config_reg_r[dcfg_pkg::LOOP_GATE_BIT];
    cfg.auto_remote       = data_config_reg_r[dcfg_pkg::AUTO_REMOTE_BIT];
    cfg.fifo_threshold    = data_config_reg_r[dcfg_pkg::THR_HI:dcfg_pkg::THR_LO];
  end

  assign cfg_out       = cfg;
  assign loopback_mode = !cfg.loopback_gate; // see (R8)

  ////////////////////////////////////////////////////////////////////////////
  // thresholds

  logic [4:0] rx_thr_bytes;
  logic [4:0] tx_thr_bytes;
  logic [4:0] thr_bytes;
  logic       req_nxt;

  // receive threshold in bytes; word mode uses the same byte count per code
  always_comb begin
    rx_thr_bytes = dcfg_pkg::rx_thresh_bytes(cfg.fifo_threshold); // see (R11)
    tx_thr_bytes = dcfg_pkg::TX_BASE_BYTES - rx_thr_bytes; // see (R13)
    thr_bytes    = transmitting ? tx_thr_bytes : rx_thr_bytes;
    req_nxt      = 1'b0;
    if (receiving) begin
      req_nxt = fifo_fill_bytes >= rx_thr_bytes; // see (R12)
    end else if (transmitting) begin
      req_nxt = fifo_fill_bytes <= tx_thr_bytes; // see (R13)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus request and burst

  logic [3:0] burst_cnt_r;
  logic       owning_r;

  // request follows the threshold until granted, then held until the burst completes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_request_out <= 1'b0;
      owning_r        <= 1'b0;
      burst_cnt_r     <= 4'h0;
    end else if (clk_en) begin
      if (!owning_r) begin
        bus_request_out <= req_nxt;
        if (bus_request_out && bus_granted) begin
          // a grant keeps the request up for the whole burst
          bus_request_out <= 1'b1;
          owning_r    <= 1'b1;
          burst_cnt_r <= burst_len; // see (R14)
        end
      end else if (dma_xfer_done) begin
        if (burst_cnt_r <= 4'h1) begin
          owning_r        <= 1'b0;
          bus_request_out <= 1'b0;
          burst_cnt_r     <= 4'h0;
        end else begin
          burst_cnt_r <= burst_cnt_r - 4'h1;
        end
      end
    end
  end

  // burst in transfers: bytes in byte mode, half as many words in word mode
  always_comb begin
    if (cfg.word_transfer_sel) begin
      burst_len = rx_thr_bytes[4:1]; // see (R1)
    end else begin
      burst_len = rx_thr_bytes[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data lanes and address

  // lane swap only in word mode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dma_ad_out <= 16'h0000;
    end else if (clk_en) begin
      if (cfg.word_transfer_sel && cfg.byte_lane_order) begin // see (R3) see (R4)
        dma_ad_out <= {dma_word_in[7:0], dma_word_in[15:8]};
      end else begin
        dma_ad_out <= dma_word_in;
      end
    end
  end

  // word mode forces A0 low; long address adds the upper half
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dma_addr_lo_out <= 16'h0000;
      dma_addr_hi_out <= 16'h0000;
      dma_addr_hi_en  <= 1'b0;
    end else if (clk_en) begin
      dma_addr_lo_out <= cfg.word_transfer_sel ? {dma_addr_in[15:1], 1'b0}
                                               : dma_addr_in; // see (R2)
      dma_addr_hi_out <= cfg.long_address_sel ? remote_start_addr : 16'h0000; // see (R6)
      dma_addr_hi_en  <= cfg.long_address_sel; // see (R5)
    end
  end

  // remove-packet only starts remote dma when auto remote is set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      remote_auto_start <= 1'b0;
    end else if (clk_en) begin
      remote_auto_start <= remove_pkt_cmd && cfg.auto_remote; // see (R9)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // byte mode passes the word straight through
  lane_swap_a: assert property (@(posedge clock) disable iff (!resetn) // see (R4)
    (clk_en && !cfg.word_transfer_sel) |=> dma_ad_out == $past(dma_word_in))
    else $error("byte mode data lanes changed");

  // word mode with swapped order exchanges the lanes
  lane_word_a: assert property (@(posedge clock) disable iff (!resetn) // see (R3)
    (clk_en && cfg.word_transfer_sel && cfg.byte_lane_order) |=>
      dma_ad_out == {$past(dma_word_in[7:0]), $past(dma_word_in[15:8])})
    else $error("word lanes not swapped");

  // word mode with normal order keeps the lanes
  lane_keep_a: assert property (@(posedge clock) disable iff (!resetn) // see (R3)
    (clk_en && cfg.word_transfer_sel && !cfg.byte_lane_order) |=>
      dma_ad_out == $past(dma_word_in))
    else $error("word lanes swapped without order bit");

  // word mode holds the lowest address bit low
  addr_a0_a: assert property (@(posedge clock) disable iff (!resetn) // see (R2)
    (clk_en && cfg.word_transfer_sel) |=> !dma_addr_lo_out[0])
    else $error("A0 not low in word mode");

  // word mode keeps the upper address bits
  addr_word_a: assert property (@(posedge clock) disable iff (!resetn) // see (R2)
    (clk_en && cfg.word_transfer_sel) |=> dma_addr_lo_out[15:1] == $past(dma_addr_in[15:1]))
    else $error("word address bits altered");

  // byte mode passes the address unchanged
  addr_byte_a: assert property (@(posedge clock) disable iff (!resetn) // see (R1)
    (clk_en && !cfg.word_transfer_sel) |=> dma_addr_lo_out == $past(dma_addr_in))
    else $error("byte address altered");

  // long address drives the remote start as upper half
  hi_addr_a: assert property (@(posedge clock) disable iff (!resetn) // see (R6)
    (clk_en && cfg.long_address_sel) |=>
      dma_addr_hi_en && dma_addr_hi_out == $past(remote_start_addr))
    else $error("upper address not driven");

  // dual channel mode leaves the upper half idle
  dual_addr_a: assert property (@(posedge clock) disable iff (!resetn) // see (R5)
    (clk_en && !cfg.long_address_sel) |=> !dma_addr_hi_en && dma_addr_hi_out == 16'h0000)
    else $error("upper address driven in dual mode");

  // remove-packet is dropped without auto remote
  auto_rem_a: assert property (@(posedge clock) disable iff (!resetn) // see (R9)
    (clk_en && remove_pkt_cmd && !cfg.auto_remote) |=> !remote_auto_start)
    else $error("remote dma started without auto remote");

  // remove-packet with auto remote starts the remote dma
  auto_go_a: assert property (@(posedge clock) disable iff (!resetn) // see (R9)
    (clk_en && remove_pkt_cmd && cfg.auto_remote) |=> remote_auto_start)
    else $error("remote dma not started");

  // no command, no start
  auto_idle_a: assert property (@(posedge clock) disable iff (!resetn) // see (R9)
    (clk_en && !remove_pkt_cmd) |=> !remote_auto_start)
    else $error("remote dma started without command");

  // burst in words is half the byte threshold
  burst_word_a: assert property (@(posedge clock) disable iff (!resetn) // see (R1)
    cfg.word_transfer_sel |->
      {burst_len, 1'b0} == dcfg_pkg::rx_thresh_bytes(cfg.fifo_threshold))
    else $error("word burst length wrong");

  // burst in bytes equals the byte threshold
  burst_byte_a: assert property (@(posedge clock) disable iff (!resetn) // see (R14)
    !cfg.word_transfer_sel |->
      {1'b0, burst_len} == dcfg_pkg::rx_thresh_bytes(cfg.fifo_threshold))
    else $error("byte burst length wrong");

  // transmit fill above its threshold keeps the request low
  tx_thr_a: assert property (@(posedge clock) disable iff (!resetn) // see (R13)
    (clk_en && !owning_r && !(bus_request_out && bus_granted) && !receiving &&
      transmitting && fifo_fill_bytes > tx_thr_bytes) |=> !bus_request_out)
    else $error("transmit request above threshold");

  // transmit fill at or below its threshold raises the request
  tx_req_hi_a: assert property (@(posedge clock) disable iff (!resetn) // see (R13)
    (clk_en && !owning_r && !receiving && transmitting &&
      fifo_fill_bytes <= tx_thr_bytes) |=> bus_request_out)
    else $error("transmit request missing");

  // receive fill below threshold keeps the request low
  rx_req_a: assert property (@(posedge clock) disable iff (!resetn) // see (R12)
    (clk_en && !owning_r && !(bus_request_out && bus_granted) && receiving &&
      fifo_fill_bytes < rx_thr_bytes) |=> !bus_request_out)
    else $error("bus requested below threshold");

  // receive fill at threshold raises the request
  rx_req_hi_a: assert property (@(posedge clock) disable iff (!resetn) // see (R12)
    (clk_en && !owning_r && receiving && fifo_fill_bytes >= rx_thr_bytes) |=> bus_request_out)
    else $error("receive request missing");

  // neither direction, no request
  idle_req_a: assert property (@(posedge clock) disable iff (!resetn) // see (R12)
    (clk_en && !owning_r && !(bus_request_out && bus_granted) && !receiving &&
      !transmitting) |=> !bus_request_out)
    else $error("request while idle");

  // a granted request loads the burst counter
  burst_load_a: assert property (@(posedge clock) disable iff (!resetn) // see (R14)
    (clk_en && !owning_r && bus_request_out && bus_granted) |=>
      owning_r && bus_request_out && burst_cnt_r == $past(burst_len))
    else $error("burst not loaded on grant");

  // the request stands while the bus is owned
  own_hold_a: assert property (@(posedge clock) disable iff (!resetn) // see (R14)
    owning_r |-> bus_request_out)
    else $error("request dropped inside burst");

  // each transfer but the last counts down
  burst_step_a: assert property (@(posedge clock) disable iff (!resetn) // see (R14)
    (clk_en && owning_r && dma_xfer_done && burst_cnt_r > 4'h1) |=>
      owning_r && burst_cnt_r == $past(burst_cnt_r) - 4'h1)
    else $error("burst count not stepped");

  // the last transfer releases the bus
  burst_end_a: assert property (@(posedge clock) disable iff (!resetn) // see (R14)
    (clk_en && owning_r && dma_xfer_done && burst_cnt_r <= 4'h1) |=>
      !owning_r && !bus_request_out)
    else $error("bus kept after last transfer");

  // a low enable freezes the state
  cfg_freeze_a: assert property (@(posedge clock) disable iff (!resetn)
    !clk_en |=> $stable(data_config_reg_r) && $stable(bus_request_out) &&
      $stable(burst_cnt_r))
    else $error("state moved while frozen");

  // a write to the index lands without bit 7
  reg_write_a: assert property (@(posedge clock) disable iff (!resetn) // see (R16)
    (clk_en && reg_wr && reg_addr == ADDR_W'(dcfg_pkg::DATA_CONFIG_IDX)) |=>
      data_config_reg_r == $past(reg_wdata[6:0]))
    else $error("register write lost");

  // writes elsewhere leave the register alone
  reg_other_a: assert property (@(posedge clock) disable iff (!resetn) // see (R16)
    (reg_wr && reg_addr != ADDR_W'(dcfg_pkg::DATA_CONFIG_IDX)) |=>
      $stable(data_config_reg_r))
    else $error("register changed by other address");

  // reads always return zero
  hi_bit_a: assert property (@(posedge clock) disable iff (!resetn) // see (R16)
    reg_rdata == 8'h00)
    else $error("register readable");

  // loopback follows the inverted gate bit
  loop_a: assert property (@(posedge clock) disable iff (!resetn) // see (R8)
    loopback_mode == !data_config_reg_r[dcfg_pkg::LOOP_GATE_BIT])
    else $error("loopback gate inverted");

endmodule : dma_data_config
